// ### hw/mcuse_core.sv
`timescale 1ns/1ns
//Contract
//RULE1: clear accumulator sets zero flag
//RULE2: invert file to destination, zero only
//RULE3: kick watchdog clears counters, sets flags
//RULE4: decrement skip, no flags touched
//RULE5: zero result discards prefetched word
//RULE6: increment file, update zero flag
//RULE7: increment skip, no flags touched
//RULE8: jump loads eleven bits plus latch
//RULE9: or accumulator with file, zero flag
//RULE10: or literal into accumulator, zero flag
//RULE11: load literal, flags unchanged
//RULE12: copy file to destination, zero flag
//RULE13: store accumulator to file, no flags
//RULE14: option load copies accumulator to option
//RULE15: interrupt exit pops, sets enable
//RULE16: table exit loads literal and pops
//RULE17: subroutine exit pops into counter
//RULE18: rotate left through carry, carry only
//RULE19: destination bit picks accumulator or file
//RULE20: zero flag follows eight bit result
module mcuse_core
  import mcuse_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic [PC_W-1:0] prog_addr,
  input wire logic [13:0] prog_data,
  input wire logic [AD_W-1:0] avm_address,
  input wire logic avm_read,
  input wire logic avm_write,
  input wire logic [31:0] avm_writedata,
  input wire logic [3:0] avm_byteenable,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic run;
  logic [13:0] instr;
  logic [PC_W-1:0] pc;
  logic [7:0] acc;
  logic carry;
  logic zero;
  logic timeout_flag_n;
  logic powerdown_flag_n;
  logic [7:0] option_reg;
  logic [7:0] irq_control_reg;
  logic [7:0] pc_high_latch;
  logic [7:0] wdog_prescale;
  logic [7:0] watchdog_counter;
  logic [7:0] file_mem [0:127];
  logic [PC_W-1:0] stack_mem [0:7];
  logic [SP_W-1:0] sp;
  logic [PC_W-1:0] stack_top;
  logic [7:0] next_readdata;
  logic bus_wr;

  ////////////////////////////////////////////////////////////////////////////
  // decode outputs
  logic [FA_W-1:0] faddr;
  logic dest_file;
  logic [7:0] fval;
  logic [7:0] lit;
  logic [7:0] res;
  logic wr_acc;
  logic wr_file;
  logic upd_zero;
  logic upd_carry;
  logic skip_test;
  logic jump;
  logic pop;
  logic kick;
  logic opt_load;
  logic gie_set;

  assign faddr = instr[FA_W-1:0];
  assign dest_file = instr[7];
  assign fval = file_mem[faddr];
  assign lit = instr[7:0];
  assign stack_top = stack_mem[sp - 3'h1];
  assign bus_wr = avm_write && !avm_waitrequest;

  // instruction decode and arithmetic, one instruction per cycle
  always_comb
  begin
    res = 8'h00;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    upd_zero = 1'b0;
    upd_carry = 1'b0;
    skip_test = 1'b0;
    jump = 1'b0;
    pop = 1'b0;
    kick = 1'b0;
    opt_load = 1'b0;
    gie_set = 1'b0;
    if (instr == OP_CLEAR_ACC)
    begin
      res = 8'h00; // RULE1
      wr_acc = 1'b1;
      upd_zero = 1'b1;
    end
    else if (instr == OP_KICK_WDG)
    begin
      kick = 1'b1; // RULE3
    end
    else if (instr == OP_OPTION_LOAD)
    begin
      opt_load = 1'b1; // RULE14
    end
    else if (instr == OP_IRQ_EXIT)
    begin
      pop = 1'b1; // RULE15
      gie_set = 1'b1;
    end
    else if (instr == OP_SUB_EXIT)
    begin
      pop = 1'b1; // RULE17
    end
    else
    begin
      case (instr[13:12])
        CLS_FILE:
        begin
          wr_acc = !dest_file; // RULE19
          wr_file = dest_file; // RULE19
          case (instr[11:8])
            NB_STORE:
            begin
              res = acc; // RULE13
              wr_acc = 1'b0;
              wr_file = instr[7];
            end
            NB_OR_FILE:
            begin
              res = acc | fval; // RULE9
              upd_zero = 1'b1;
            end
            NB_COPY:
            begin
              res = fval; // RULE12
              upd_zero = 1'b1;
            end
            NB_INVERT:
            begin
              res = ~fval; // RULE2
              upd_zero = 1'b1;
            end
            NB_INC:
            begin
              res = fval + 8'h01; // RULE6
              upd_zero = 1'b1;
            end
            NB_DEC_SKIP:
            begin
              res = fval - 8'h01; // RULE4
              skip_test = 1'b1;
            end
            NB_INC_SKIP:
            begin
              res = fval + 8'h01; // RULE7
              skip_test = 1'b1;
            end
            NB_ROT_LEFT:
            begin
              res = {fval[6:0], carry}; // RULE18
              upd_carry = 1'b1;
            end
            default:
            begin
              wr_acc = 1'b0;
              wr_file = 1'b0;
            end
          endcase
        end
        CLS_JUMP:
        begin
          jump = instr[11]; // RULE8
        end
        CLS_LIT:
        begin
          if (instr[11:10] == NB_LOAD_LIT)
          begin
            res = lit; // RULE11
            wr_acc = 1'b1;
          end
          else if (instr[11:10] == NB_TABLE_EXIT)
          begin
            res = lit; // RULE16
            wr_acc = 1'b1;
            pop = 1'b1;
          end
          else if (instr[11:8] == NB_OR_LIT)
          begin
            res = acc | lit; // RULE10
            wr_acc = 1'b1;
            upd_zero = 1'b1;
          end
        end
        default:
        begin
          res = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch pipeline: instr executes while the word at pc is fetched
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      instr <= NOP_WORD;
      pc <= PC_RST;
    end
    else if (run)
    begin
      if (jump)
      begin
        pc <= {pc_high_latch[HL_HI:HL_LO], instr[10:0]}; // RULE8
        instr <= NOP_WORD; // RULE8
      end
      else if (pop)
      begin
        pc <= stack_top; // RULE15 RULE16 RULE17
        instr <= NOP_WORD;
      end
      else if (skip_test && res == 8'h00)
      begin
        pc <= pc + 13'h0001;
        instr <= NOP_WORD; // RULE5
      end
      else
      begin
        pc <= pc + 13'h0001;
        instr <= prog_data;
      end
    end
    else if (bus_wr && avm_address == REG_PC && avm_byteenable[0])
    begin
      pc <= avm_writedata[PC_W-1:0];
      instr <= NOP_WORD;
    end
  end

  // program memory address comes from the counter flop
  assign prog_addr = pc;

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and status flags
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc <= 8'h00;
      carry <= 1'b0;
      zero <= 1'b0;
    end
    else if (run)
    begin
      if (wr_acc)
      begin
        acc <= res;
      end
      if (upd_zero)
      begin
        zero <= (res == 8'h00); // RULE20
      end
      if (upd_carry)
      begin
        carry <= fval[7]; // RULE18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // file memory: core writes while running, bus writes only when halted
  always_ff @(posedge sys_clk)
  begin
    if (run && wr_file)
    begin
      file_mem[faddr] <= res; // RULE19
    end
    else if (!run && bus_wr && avm_address[9] == FILE_WIN[1]
             && avm_byteenable[0])
    begin
      file_mem[avm_address[8:2]] <= avm_writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // return stack, filled from the bus push register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sp <= 3'h0;
    end
    else if (run && pop && !jump)
    begin
      sp <= sp - 3'h1; // RULE17
    end
    else if (bus_wr && avm_address == REG_PUSH)
    begin
      sp <= sp + 3'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (bus_wr && avm_address == REG_PUSH && !(run && pop))
    begin
      stack_mem[sp] <= avm_writedata[PC_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog prescaler, counter and the two power flags
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wdog_prescale <= 8'h00;
      watchdog_counter <= 8'h00;
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end
    else if (run && kick)
    begin
      wdog_prescale <= 8'h00; // RULE3
      watchdog_counter <= 8'h00; // RULE3
      timeout_flag_n <= 1'b1; // RULE3
      powerdown_flag_n <= 1'b1; // RULE3
    end
    else if (run)
    begin
      wdog_prescale <= wdog_prescale + 8'h01;
      if (wdog_prescale == 8'hFF)
      begin
        watchdog_counter <= watchdog_counter + 8'h01;
        if (watchdog_counter == 8'hFF)
        begin
          timeout_flag_n <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers: run control, latch, irq control, option
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run <= 1'b0;
      pc_high_latch <= PCHL_RST;
      irq_control_reg <= IRQCTL_RST;
      option_reg <= OPTION_RST;
    end
    else
    begin
      if (bus_wr && avm_byteenable[0])
      begin
        case (avm_address)
          REG_CTRL: run <= avm_writedata[0];
          REG_PCHL: pc_high_latch <= avm_writedata[7:0];
          REG_IRQCTL: irq_control_reg <= avm_writedata[7:0];
          REG_OPTION: option_reg <= avm_writedata[7:0]; // RULE14
          default: run <= run;
        endcase
      end
      if (run && gie_set)
      begin
        irq_control_reg[IRQ_GIE] <= 1'b1; // RULE15
      end
      if (run && opt_load)
      begin
        option_reg <= acc; // RULE14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, low byte lanes; unmapped reads return zero
  always_comb
  begin
    next_readdata = 8'h00;
    case (avm_address)
      REG_CTRL: next_readdata = {7'h00, run};
      REG_ACC: next_readdata = acc;
      REG_STATUS: next_readdata = {3'h0, timeout_flag_n,
                                   powerdown_flag_n, zero, 1'b0, carry};
      REG_PC: next_readdata = pc[7:0];
      REG_PCHL: next_readdata = pc_high_latch;
      REG_IRQCTL: next_readdata = irq_control_reg;
      REG_OPTION: next_readdata = option_reg;
      REG_WDOG: next_readdata = watchdog_counter;
      default:
      begin
        // window spans 0x200 to 0x3FC, so bit 9 alone selects it
        if (avm_address[9] == FILE_WIN[1])
        begin
          next_readdata = file_mem[avm_address[8:2]];
        end
      end
    endcase
  end

  // one wait cycle per access; readdata is set as waitrequest drops
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avm_waitrequest <= 1'b1;
      avm_readdata <= 32'h0000_0000;
    end
    else if (avm_waitrequest && (avm_read || avm_write))
    begin
      avm_waitrequest <= 1'b0;
      if (avm_address == REG_PC)
      begin
        avm_readdata <= {19'h00000, pc};
      end
      else
      begin
        avm_readdata <= {24'h000000, next_readdata};
      end
    end
    else
    begin
      avm_waitrequest <= 1'b1;
    end
  end

endmodule

// ### hw/mcuse_pkg.sv
package mcuse_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int PC_W = 13;
  localparam int FA_W = 7;
  localparam int SP_W = 3;
  localparam int AD_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // instruction words and opcode fields
  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam logic [13:0] OP_CLEAR_ACC = 14'h0103;
  localparam logic [13:0] OP_KICK_WDG = 14'h0064;
  localparam logic [13:0] OP_OPTION_LOAD = 14'h0062;
  localparam logic [13:0] OP_IRQ_EXIT = 14'h0009;
  localparam logic [13:0] OP_SUB_EXIT = 14'h0008;
  localparam logic [1:0] CLS_FILE = 2'h0;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  localparam logic [3:0] NB_STORE = 4'h0;
  localparam logic [3:0] NB_OR_FILE = 4'h4;
  localparam logic [3:0] NB_COPY = 4'h8;
  localparam logic [3:0] NB_INVERT = 4'h9;
  localparam logic [3:0] NB_INC = 4'hA;
  localparam logic [3:0] NB_DEC_SKIP = 4'hB;
  localparam logic [3:0] NB_ROT_LEFT = 4'hD;
  localparam logic [3:0] NB_INC_SKIP = 4'hF;
  localparam logic [3:0] NB_OR_LIT = 4'h8;
  localparam logic [1:0] NB_LOAD_LIT = 2'h0;
  localparam logic [1:0] NB_TABLE_EXIT = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // flag positions
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO = 2;
  localparam int ST_PD_N = 3;
  localparam int ST_TO_N = 4;
  localparam int IRQ_GIE = 7;
  localparam int HL_LO = 3;
  localparam int HL_HI = 4;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] IRQCTL_RST = 8'h00;
  localparam logic [7:0] PCHL_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [AD_W-1:0] REG_CTRL = 10'h000;
  localparam logic [AD_W-1:0] REG_ACC = 10'h004;
  localparam logic [AD_W-1:0] REG_STATUS = 10'h008;
  localparam logic [AD_W-1:0] REG_PC = 10'h00C;
  localparam logic [AD_W-1:0] REG_PCHL = 10'h010;
  localparam logic [AD_W-1:0] REG_IRQCTL = 10'h014;
  localparam logic [AD_W-1:0] REG_OPTION = 10'h018;
  localparam logic [AD_W-1:0] REG_WDOG = 10'h01C;
  localparam logic [AD_W-1:0] REG_PUSH = 10'h020;
  localparam logic [1:0] FILE_WIN = 2'h2;
endpackage

// ### tb/mcuse_core_monitor.sv
`timescale 1ns/1ns
module mcuse_core_monitor
  import mcuse_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [13:0] prog_data,
  input wire logic [AD_W-1:0] avm_address,
  input wire logic avm_read,
  input wire logic avm_write,
  input wire logic [31:0] avm_writedata,
  input wire logic [3:0] avm_byteenable,
  input wire logic [31:0] avm_readdata,
  input wire logic avm_waitrequest
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // a fetched jump word that really advanced the counter
  sequence s_jump;
    (prog_data[13:11] == 3'b101) ##1 (prog_addr == $past(prog_addr) + 1'b1);
  endsequence
  // target low bits come from the jump word, two edges after its fetch
  property p_jump;
    s_jump |=> $stable(prog_addr) ||
      (prog_addr[10:0] == $past(prog_data[10:0], 2));
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  // after the target the fetch resumes one word a cycle
  property p_jump_next;
    s_jump ##1 !$stable(prog_addr) |=>
      $stable(prog_addr) || (prog_addr == $past(prog_addr) + 1'b1);
  endproperty
  a_jump_next: assert property (p_jump_next)
    else $error("no fetch after jump target");

  ////////////////////////////////////////////////////////////////////////////
  // bus answers with exactly one wait state
  property p_wait;
    (avm_read || avm_write) && avm_waitrequest |=> !avm_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state count wrong");
  property p_wait_one;
    !avm_waitrequest |=> avm_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("ready held too long");
  property p_wait_cause;
    !avm_waitrequest |-> $past(avm_read || avm_write);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("ready unasked");
  property p_unmapped;
    avm_read && !avm_waitrequest && avm_address > 10'h020 &&
      avm_address < 10'h200 |-> avm_readdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
  property p_upper;
    avm_read && !avm_waitrequest |-> avm_readdata[31:13] == 19'h00000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_hold;
    avm_waitrequest && $past(avm_waitrequest) |-> $stable(avm_readdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data changed idle");

  ////////////////////////////////////////////////////////////////////////////
  // main scenarios reached
  c_jump: cover property (s_jump);
  c_read: cover property (avm_read && !avm_waitrequest);
  c_write: cover property (avm_write && !avm_waitrequest);
endmodule

bind mcuse_core mcuse_core_monitor u_mon (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .prog_addr(prog_addr),
  .prog_data(prog_data),
  .avm_address(avm_address),
  .avm_read(avm_read),
  .avm_write(avm_write),
  .avm_writedata(avm_writedata),
  .avm_byteenable(avm_byteenable),
  .avm_readdata(avm_readdata),
  .avm_waitrequest(avm_waitrequest)
);

// ### tb/mcuse_prog_mem.sv
`timescale 1ns/1ns
module mcuse_prog_mem
  import mcuse_pkg::*;
(
  input wire logic [PC_W-1:0] prog_addr,
  output logic [13:0] prog_data
);
  logic [13:0] mem [0:8191];
  // unwritten words read as no-operation
  initial
  begin
    for (int i = 0; i < 8192; i++)
      mem[i] = NOP_WORD;
  end
  // answer within the fetch cycle
  assign prog_data = mem[prog_addr];
endmodule

// ### tb/mcu_instruction_subset_exec_bench.sv
`timescale 1ns/1ns
module mcu_instruction_subset_exec_bench
  import mcuse_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [PC_W-1:0] prog_addr;
  logic [13:0] prog_data;
  logic [AD_W-1:0] avm_address = 10'h000;
  logic avm_read = 1'b0;
  logic avm_write = 1'b0;
  logic [31:0] avm_writedata = 32'h00000000;
  logic [3:0] avm_byteenable = 4'hF;
  logic [31:0] avm_readdata;
  logic avm_waitrequest;
  logic [31:0] q;
  int miscompares = 0;
  int total_checks = 0;

  mcuse_core u_dut (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .avm_address(avm_address),
    .avm_read(avm_read),
    .avm_write(avm_write),
    .avm_writedata(avm_writedata),
    .avm_byteenable(avm_byteenable),
    .avm_readdata(avm_readdata),
    .avm_waitrequest(avm_waitrequest)
  );
  mcuse_prog_mem u_mem (
    .prog_addr(prog_addr),
    .prog_data(prog_data)
  );

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task fail_out;
    miscompares++;
    $display("[ERR] %0t wait ran out", $time);
    test_done();
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task bus(input logic wr, input logic [AD_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avm_address <= a;
    avm_writedata <= d;
    avm_write <= wr;
    avm_read <= !wr;
    @(posedge sys_clk);
    while (avm_waitrequest !== 1'b0)
    begin
      n++;
      if (n > 20)
        fail_out();
      @(posedge sys_clk);
    end
    q = avm_readdata;
    avm_write <= 1'b0;
    avm_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wr(input logic [AD_W-1:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d});
  endtask
  task rd(input logic [AD_W-1:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(q, {24'h000000, exp});
  endtask
  function automatic logic [AD_W-1:0] fa(input int f);
    return AD_W'(10'h200 + 4 * f);
  endfunction
  function automatic logic [13:0] fop(input logic [3:0] nb, input logic d,
    input int f);
    return {CLS_FILE, nb, d, 7'(f)};
  endfunction
  // literal load with both don't-care bits set
  function automatic logic [13:0] ld(input logic [7:0] k);
    return {CLS_LIT, NB_LOAD_LIT, 2'h3, k};
  endfunction
  // run from 0 until the spin loop is fetched, then halt
  task go(input int loop);
    int n;
    u_mem.mem[loop] = {CLS_JUMP, 1'b1, 11'(loop)};
    wr(REG_PC, 8'h00);
    wr(REG_CTRL, 8'h01);
    n = 0;
    while (prog_addr !== PC_W'(loop))
    begin
      n++;
      if (n > 200)
        fail_out();
      @(posedge sys_clk);
    end
    wr(REG_CTRL, 8'h00);
  endtask
  task prog(input logic [13:0] a, b, c, d, e, f);
    u_mem.mem[0] = a;
    u_mem.mem[1] = b;
    u_mem.mem[2] = c;
    u_mem.mem[3] = d;
    u_mem.mem[4] = e;
    u_mem.mem[5] = f;
    go(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset, then one program per test and two in test 9, results read back over the bus
  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(REG_STATUS, 8'h18);
    // unmapped offset below the file window reads as zero
    rd(10'h024, 8'h00);
    wr(fa(127), 8'h00);
    prog(ld(8'h5A), fop(NB_STORE, 1'b1, 127), OP_CLEAR_ACC, NOP_WORD,
      NOP_WORD, NOP_WORD);
    rd(REG_ACC, 8'h00);
    rd(REG_STATUS, 8'h1C);
    rd(fa(127), 8'h5A);
    $display("test 1 done");
    wr(fa(10), 8'h13);
    prog(fop(NB_INVERT, 1'b0, 10), fop(NB_STORE, 1'b1, 11), ld(8'h00),
      NOP_WORD, NOP_WORD, NOP_WORD);
    rd(fa(11), 8'hEC);
    rd(fa(10), 8'h13);
    rd(REG_ACC, 8'h00);
    rd(REG_STATUS, 8'h18);
    $display("test 2 done");
    wr(fa(12), 8'h00);
    wr(fa(20), 8'h00);
    prog(ld(8'h91), fop(NB_OR_FILE, 1'b0, 10), fop(NB_OR_FILE, 1'b1, 12),
      fop(NB_COPY, 1'b1, 20), NOP_WORD, NOP_WORD);
    rd(REG_ACC, 8'h93);
    rd(fa(12), 8'h93);
    rd(REG_STATUS, 8'h1C);
    $display("test 3 done");
    prog(ld(8'h9A), {CLS_LIT, NB_OR_LIT, 8'h35}, fop(NB_STORE, 1'b1, 21),
      fop(NB_COPY, 1'b0, 10), NOP_WORD, NOP_WORD);
    rd(fa(21), 8'hBF);
    rd(REG_ACC, 8'h13);
    rd(REG_STATUS, 8'h18);
    $display("test 4 done");
    wr(fa(22), 8'hFF);
    wr(fa(23), 8'h7F);
    prog(fop(NB_INC, 1'b0, 23), fop(NB_INC, 1'b1, 22), NOP_WORD, NOP_WORD,
      NOP_WORD, NOP_WORD);
    rd(REG_ACC, 8'h80);
    rd(fa(22), 8'h00);
    rd(REG_STATUS, 8'h1C);
    $display("test 5 done");
    wr(fa(24), 8'h01);
    wr(fa(25), 8'hFF);
    prog({CLS_LIT, NB_OR_LIT, 8'h01}, fop(NB_DEC_SKIP, 1'b1, 24), ld(8'h11),
      fop(NB_INC_SKIP, 1'b1, 25), ld(8'h22), NOP_WORD);
    rd(REG_ACC, 8'h81);
    rd(fa(24), 8'h00);
    rd(fa(25), 8'h00);
    rd(REG_STATUS, 8'h18);
    $display("test 6 done");
    wr(fa(26), 8'h05);
    prog(fop(NB_DEC_SKIP, 1'b0, 26), fop(NB_STORE, 1'b1, 27),
      fop(NB_INC_SKIP, 1'b0, 26), NOP_WORD, NOP_WORD, NOP_WORD);
    rd(fa(27), 8'h04);
    rd(REG_ACC, 8'h06);
    $display("test 7 done");
    wr(fa(40), 8'hE6);
    prog(OP_CLEAR_ACC, fop(NB_ROT_LEFT, 1'b0, 40), fop(NB_ROT_LEFT, 1'b1, 40),
      NOP_WORD, NOP_WORD, NOP_WORD);
    rd(REG_ACC, 8'hCC);
    rd(fa(40), 8'hCD);
    rd(REG_STATUS, 8'h1D);
    $display("test 8 done");
    // legacy option load used here only to exercise it
    prog(ld(8'h4F), OP_OPTION_LOAD, NOP_WORD, NOP_WORD, NOP_WORD,
      NOP_WORD);
    rd(REG_OPTION, 8'h4F);
    wr(REG_CTRL, 8'h01);
    repeat (600) @(posedge sys_clk);
    wr(REG_CTRL, 8'h00);
    bus(1'b0, REG_WDOG, 32'h00000000);
    check({31'h00000000, q != 32'h00000000}, 32'h00000001);
    prog(OP_KICK_WDG, NOP_WORD, NOP_WORD, NOP_WORD, NOP_WORD, NOP_WORD);
    rd(REG_WDOG, 8'h00);
    rd(REG_STATUS, 8'h1D);
    $display("test 9 done");
    wr(REG_IRQCTL, 8'h00);
    wr(REG_PUSH, 8'h40);
    wr(REG_PUSH, 8'h50);
    wr(REG_PUSH, 8'h60);
    u_mem.mem[0] = OP_SUB_EXIT;
    u_mem.mem[1] = ld(8'h99);
    u_mem.mem[8'h60] = {CLS_LIT, NB_TABLE_EXIT, 2'h2, 8'h77};
    u_mem.mem[8'h61] = ld(8'h98);
    u_mem.mem[8'h50] = OP_IRQ_EXIT;
    u_mem.mem[8'h51] = ld(8'h97);
    go(8'h40);
    rd(REG_ACC, 8'h77);
    rd(REG_IRQCTL, 8'h80);
    rd(REG_STATUS, 8'h1D);
    $display("test 10 done");
    wr(REG_PCHL, 8'h08);
    u_mem.mem[0] = {CLS_JUMP, 1'b1, 11'h123};
    u_mem.mem[1] = ld(8'h55);
    u_mem.mem[13'h0923] = ld(8'h3C);
    go(13'h0924);
    rd(REG_ACC, 8'h3C);
    $display("test 11 done");
    test_done();
  end
endmodule
